// ==== immediate_shift_rotate_mul_unit.sv ====
`timescale 1ns/100ps
// Behaviour
// - Push immediate takes byte or word; byte is sign-extended to a word.
// - Immediate multiply: destination, source multiplier, immediate multiplicand, signed.
// - Multiplier may be the destination register, another register or memory.
// - Byte immediate multiplicand is sign-extended to 16 bits first.
// - Only the low 16 bits of the product are kept.
// - Shift count is an immediate byte ANDed with 1FH, at most 31 steps.
// - Arithmetic left shift fills vacated low bits with zero.
// - Logical left shift is identical to arithmetic left shift.
// - Arithmetic right shift copies the original sign bit into the top.
// - Logical right shift behaves exactly like arithmetic right shift.
// - Rotates work on byte or word operands with an immediate byte count.
// - Left rotate moves the top bit into the bottom bit each step.
// - Right rotate moves the bottom bit into the top bit each step.
// - Left rotate through carry: carry into bottom, old top into carry.
// - Right rotate through carry: carry into top, old bottom into carry.
// - Carry reflects the last bit carried out (high end on left moves, low end on right moves); feeds carry rotates.
module immediate_shift_rotate_mul_unit
  import imm_alu_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_req_valid,
  input wire req_type i_req,
  output rsp_type o_rsp,
  output logic o_rsp_valid
);

  rsp_type rsp;
  rsp_type next_rsp;
  logic rsp_valid;
  logic next_rsp_valid;
  logic [4:0] count_masked;
  logic [15:0] operand;
  logic [15:0] multiplier;
  logic [15:0] multiplicand;
  logic [31:0] product;
  logic [16:0] shifted;

  // Byte to word sign extension, shared by push and multiply
  function automatic logic [15:0] sext8(input logic [7:0] b);
    sext8 = {{BYTE_W{b[BYTE_W-1]}}, b};
  endfunction

  // Bit-serial model of the shift group; returns {carry, result}
  function automatic logic [16:0] shift_rot(input op_type op, input logic byte_op,
                                             input logic [15:0] val, input logic cin,
                                             input logic [4:0] cnt);
    logic [15:0] d;
    logic c;
    logic top;
    logic low;
    logic sign;
    int msb;
    msb = byte_op ? BYTE_MSB : WORD_MSB;
    d = val;
    c = cin;
    sign = val[msb];
    for (int i = 0; i < MAX_STEPS; i++) begin
      if (i < int'(cnt)) begin
        top = d[msb];
        low = d[0];
        case (op)
          op_arith_shift_left_imm, op_logic_shift_left_imm: begin
            c = top;
            d = d << 1;
          end
          op_arith_shift_right_imm, op_logic_shift_right_imm: begin
            c = low;
            d = d >> 1;
            d[msb] = sign;
          end
          op_rotate_left_imm: begin
            c = top;
            d = d << 1;
            d[0] = top;
          end
          op_rotate_right_imm: begin
            c = low;
            d = d >> 1;
            d[msb] = low;
          end
          op_rotate_left_thru_carry: begin
            d = d << 1;
            d[0] = c;
            c = top;
          end
          op_rotate_right_thru_carry: begin
            d = d >> 1;
            d[msb] = c;
            c = low;
          end
          default: begin
            d = d;
          end
        endcase
      end
    end
    // Bits pushed above a byte operand are dropped so the upper byte reads zero
    if (byte_op) begin
      d[15:8] = 8'h00;
    end
    shift_rot = {c, d};
  endfunction

  // Operand shaping and the multiplier path
  always_comb begin
    count_masked = 5'(i_req.count & COUNT_MASK);
    operand = i_req.byte_op ? {8'h00, i_req.dest[7:0]} : i_req.dest;
    case (i_req.msrc)
      msrc_dest: multiplier = i_req.dest;
      msrc_reg: multiplier = i_req.other_reg;
      msrc_mem: multiplier = i_req.mem;
      default: multiplier = i_req.dest;
    endcase
    multiplicand = i_req.imm_byte ? sext8(i_req.imm[7:0]) : i_req.imm;
    product = $signed(multiplier) * $signed(multiplicand);
    shifted = shift_rot(i_req.op, i_req.byte_op, operand, i_req.carry_flag, count_masked);
  end

  // Next response; write strobes last one cycle, result holds until the next request with a defined op
  always_comb begin
    next_rsp = rsp;
    next_rsp.carry_we = 1'b0;
    next_rsp.dest_we = 1'b0;
    next_rsp.stack_we = 1'b0;
    next_rsp_valid = i_req_valid;
    if (i_req_valid) begin
      case (i_req.op)
        op_push_imm: begin
          next_rsp.result = i_req.imm_byte ? sext8(i_req.imm[7:0]) : i_req.imm;
          next_rsp.stack_we = 1'b1;
        end
        op_signed_immediate_multiply: begin
          // Destination is always a register, so only a register write strobe
          next_rsp.result = product[15:0];
          next_rsp.dest_we = 1'b1;
        end
        op_arith_shift_left_imm, op_logic_shift_left_imm, op_arith_shift_right_imm,
        op_logic_shift_right_imm, op_rotate_left_imm, op_rotate_right_imm,
        op_rotate_left_thru_carry, op_rotate_right_thru_carry: begin
          if (count_masked == 5'h00) begin
            // Nothing moves, so neither operand nor carry is written
            next_rsp.result = operand;
          end else begin
            next_rsp.result = shifted[15:0];
            next_rsp.carry_flag = shifted[16];
            next_rsp.carry_we = 1'b1;
            next_rsp.dest_we = 1'b1;
          end
        end
        default: begin
          next_rsp_valid = 1'b0;
        end
      endcase
    end
  end

  // Response registers
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rsp <= RSP_RESET;
      rsp_valid <= RESP_VALID_RESET;
    end else begin
      rsp <= next_rsp;
      rsp_valid <= next_rsp_valid;
    end
  end

  assign o_rsp = rsp;
  assign o_rsp_valid = rsp_valid;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);

  // Byte push comes out sign-extended one cycle later
  property p_push_sext;
    i_req_valid && i_req.op == op_push_imm && i_req.imm_byte
      |=> o_rsp.stack_we && o_rsp.result == {{8{$past(i_req.imm[7])}}, $past(i_req.imm[7:0])};
  endproperty
  a_push_sext: assert property (p_push_sext) else $error("push byte not sign extended");

  // Word multiply from the destination keeps the low product half
  property p_mul_dest;
    i_req_valid && i_req.op == op_signed_immediate_multiply && i_req.msrc == msrc_dest
      && !i_req.imm_byte
      |=> o_rsp.dest_we && o_rsp.result == 16'($past(i_req.dest) * $past(i_req.imm));
  endproperty
  a_mul_dest: assert property (p_mul_dest) else $error("multiply low word wrong");

  // Memory multiplier with a byte immediate
  property p_mul_mem_byte;
    i_req_valid && i_req.op == op_signed_immediate_multiply && i_req.msrc == msrc_mem
      && i_req.imm_byte
      |=> o_rsp.result == 16'($past(i_req.mem) * {{8{$past(i_req.imm[7])}},
                                                     $past(i_req.imm[7:0])});
  endproperty
  a_mul_mem_byte: assert property (p_mul_mem_byte) else $error("byte multiply wrong");

  // Other register as multiplier
  property p_mul_reg;
    i_req_valid && i_req.op == op_signed_immediate_multiply && i_req.msrc == msrc_reg
      && !i_req.imm_byte
      |=> o_rsp.result == 16'($past(i_req.other_reg) * $past(i_req.imm));
  endproperty
  a_mul_reg: assert property (p_mul_reg) else $error("register multiplier wrong");

  // Upper count bits are ignored on a word left shift
  property p_shl_mask;
    i_req_valid && !i_req.byte_op && i_req.count[4:0] != 5'h00
      && (i_req.op == op_arith_shift_left_imm || i_req.op == op_logic_shift_left_imm)
      |=> o_rsp.result == 16'($past(i_req.dest) << $past(i_req.count[4:0]));
  endproperty
  a_shl_mask: assert property (p_shl_mask) else $error("left shift result wrong");

  // Left shift carry is the last bit pushed out of the top
  property p_shl_carry;
    i_req_valid && !i_req.byte_op && i_req.op == op_arith_shift_left_imm
      && count_masked == 5'h01
      |=> o_rsp.carry_we && o_rsp.carry_flag == $past(i_req.dest[15]);
  endproperty
  a_shl_carry: assert property (p_shl_carry) else $error("shift carry wrong");

  // Word right shift keeps the sign
  property p_sar;
    i_req_valid && !i_req.byte_op && count_masked != 5'h00
      && (i_req.op == op_arith_shift_right_imm || i_req.op == op_logic_shift_right_imm)
      |=> o_rsp.result == 16'($signed($past(i_req.dest)) >>> $past(count_masked));
  endproperty
  a_sar: assert property (p_sar) else $error("right shift lost sign");

  // Single-step word rotates
  property p_rol;
    i_req_valid && !i_req.byte_op && i_req.op == op_rotate_left_imm && count_masked == 5'h01
      |=> o_rsp.result == {$past(i_req.dest[14:0]), $past(i_req.dest[15])};
  endproperty
  a_rol: assert property (p_rol) else $error("left rotate wrong");

  property p_ror;
    i_req_valid && !i_req.byte_op && i_req.op == op_rotate_right_imm && count_masked == 5'h01
      |=> o_rsp.result == {$past(i_req.dest[0]), $past(i_req.dest[15:1])};
  endproperty
  a_ror: assert property (p_ror) else $error("right rotate wrong");

  property p_rcl;
    i_req_valid && !i_req.byte_op && i_req.op == op_rotate_left_thru_carry
      && count_masked == 5'h01
      |=> o_rsp.result == {$past(i_req.dest[14:0]), $past(i_req.carry_flag)}
          && o_rsp.carry_flag == $past(i_req.dest[15]);
  endproperty
  a_rcl: assert property (p_rcl) else $error("carry left rotate wrong");

  property p_rcr;
    i_req_valid && !i_req.byte_op && i_req.op == op_rotate_right_thru_carry
      && count_masked == 5'h01
      |=> o_rsp.result == {$past(i_req.carry_flag), $past(i_req.dest[15:1])}
          && o_rsp.carry_flag == $past(i_req.dest[0]);
  endproperty
  a_rcr: assert property (p_rcr) else $error("carry right rotate wrong");

  // Byte rotate stays inside the low byte
  property p_rol_byte;
    i_req_valid && i_req.byte_op && i_req.op == op_rotate_left_imm && count_masked == 5'h01
      |=> o_rsp.result == {8'h00, $past(i_req.dest[6:0]), $past(i_req.dest[7])};
  endproperty
  a_rol_byte: assert property (p_rol_byte) else $error("byte rotate wrong");

  // Zero masked count writes nothing
  property p_zero_count;
    i_req_valid && i_req.op != op_push_imm && i_req.op != op_signed_immediate_multiply
      && i_req.count[4:0] == 5'h00
      |=> !o_rsp.carry_we && !o_rsp.dest_we;
  endproperty
  a_zero_count: assert property (p_zero_count) else $error("zero count changed state");

  // Word push passes the immediate through untouched
  property p_push_word;
    i_req_valid && i_req.op == op_push_imm && !i_req.imm_byte
      |=> o_rsp.stack_we && !o_rsp.dest_we && !o_rsp.carry_we
          && o_rsp.result == $past(i_req.imm);
  endproperty
  a_push_word: assert property (p_push_word) else $error("push word wrong");

  // Multiply only ever writes a register, never the stack or the carry
  property p_mul_strobes;
    i_req_valid && i_req.op == op_signed_immediate_multiply
      |=> o_rsp_valid && o_rsp.dest_we && !o_rsp.stack_we && !o_rsp.carry_we;
  endproperty
  a_mul_strobes: assert property (p_mul_strobes) else $error("multiply strobes wrong");

  // Byte left shift brings a zero in at the bottom and drops bit 7 into carry
  property p_shl_byte;
    i_req_valid && i_req.byte_op && i_req.op == op_arith_shift_left_imm
      && count_masked == 5'h01
      |=> o_rsp.result == {8'h00, $past(i_req.dest[6:0]), 1'b0}
          && o_rsp.carry_flag == $past(i_req.dest[7]);
  endproperty
  a_shl_byte: assert property (p_shl_byte) else $error("byte left shift wrong");

  // Byte right shift treats bit 7 as the sign
  property p_sar_byte;
    i_req_valid && i_req.byte_op && i_req.op == op_arith_shift_right_imm
      && count_masked == 5'h01
      |=> o_rsp.result == {8'h00, $past(i_req.dest[7]), $past(i_req.dest[7:1])};
  endproperty
  a_sar_byte: assert property (p_sar_byte) else $error("byte right shift wrong");

  // Byte carry rotate feeds the carry into bit 7, not bit 15
  property p_rcr_byte;
    i_req_valid && i_req.byte_op && i_req.op == op_rotate_right_thru_carry
      && count_masked == 5'h01
      |=> o_rsp.result == {8'h00, $past(i_req.carry_flag), $past(i_req.dest[7:1])}
          && o_rsp.carry_flag == $past(i_req.dest[0]);
  endproperty
  a_rcr_byte: assert property (p_rcr_byte) else $error("byte carry rotate wrong");

endmodule

// ==== imm_alu_pkg.sv ====
package imm_alu_pkg;

  // Datapath geometry
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int COUNT_W = 5;
  localparam int WORD_MSB = 15;
  localparam int BYTE_MSB = 7;
  localparam int MAX_STEPS = 32;
  localparam logic [7:0] COUNT_MASK = 8'h1F;

  // Values after reset
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic RESP_VALID_RESET = 1'b0;

  // Operations issued by the decoder
  typedef enum logic [3:0] {
    op_push_imm,
    op_signed_immediate_multiply,
    op_arith_shift_left_imm,
    op_logic_shift_left_imm,
    op_arith_shift_right_imm,
    op_logic_shift_right_imm,
    op_rotate_left_imm,
    op_rotate_right_imm,
    op_rotate_left_thru_carry,
    op_rotate_right_thru_carry
  } op_type;

  // Where the multiplier of the immediate multiply comes from
  typedef enum logic [1:0] {
    msrc_dest,
    msrc_reg,
    msrc_mem
  } msrc_type;

  typedef struct packed {
    op_type op;
    logic byte_op;
    logic imm_byte;
    msrc_type msrc;
    logic [7:0] count;
    logic [15:0] imm;
    logic [15:0] dest;
    logic [15:0] other_reg;
    logic [15:0] mem;
    logic carry_flag;
  } req_type;

  typedef struct packed {
    logic [15:0] result;
    logic carry_flag;
    logic carry_we;
    logic dest_we;
    logic stack_we;
  } rsp_type;

  localparam rsp_type RSP_RESET = '{RESULT_RESET, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage

// ==== decoder_model.sv ====
`timescale 1ns/100ps
module decoder_model
  import imm_alu_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_cmd_valid,
  input wire req_type i_cmd,
  input wire rsp_type i_rsp,
  input wire logic i_rsp_valid,
  output logic o_req_valid,
  output req_type o_req,
  output logic o_carry_flag,
  output logic [15:0] o_dest_reg
);
  // Issue one request per command; idle fields toggle so stale values never look valid
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_req_valid <= 1'b0;
      o_req <= '0;
      o_carry_flag <= 1'b0;
      o_dest_reg <= 16'h0000;
    end else begin
      o_req_valid <= i_cmd_valid;
      o_req <= i_cmd_valid ? i_cmd : ~o_req;
      o_req.carry_flag <= o_carry_flag;
      if (i_rsp_valid && i_rsp.carry_we) begin
        o_carry_flag <= i_rsp.carry_flag;
      end
      // Multiply results only ever land in a register
      if (i_rsp_valid && i_rsp.dest_we) begin
        o_dest_reg <= i_rsp.result;
      end
    end
  end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import imm_alu_pkg::*;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  req_type cmd = '0;
  req_type req;
  rsp_type rsp;
  logic req_valid, rsp_valid, p_carry, exp_c;
  logic [15:0] p_dest, last_res;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  req_type r;
  logic [7:0] cnts [10] = '{8'h00, 8'h01, 8'h07, 8'h08, 8'h0F, 8'h10, 8'h11, 8'h1F, 8'h20, 8'hFF};

  decoder_model u_decoder_model (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_rsp(rsp), .i_rsp_valid(rsp_valid),
    .o_req_valid(req_valid), .o_req(req), .o_carry_flag(p_carry), .o_dest_reg(p_dest));
  immediate_shift_rotate_mul_unit u_immediate_shift_rotate_mul_unit (.i_mclk(i_mclk),
    .i_arst_n(i_arst_n), .i_req_valid(req_valid), .i_req(req), .o_rsp(rsp),
    .o_rsp_valid(rsp_valid));

  initial forever #4 i_mclk = ~i_mclk;

  // Hang guard, far above the roughly 1900 cycles the tests need
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Reference: bit-serial walk of each step; we = {carry_we, dest_we, stack_we}
  function automatic void expect_of(input req_type q, input logic cin, output logic [15:0] v,
                                    output logic c, output logic [2:0] we);
    logic [15:0] m, k;
    logic t, b;
    int w, n;
    w = q.byte_op ? 8 : 16;
    n = q.count & COUNT_MASK;
    k = q.imm_byte ? {{8{q.imm[7]}}, q.imm[7:0]} : q.imm;
    m = (q.msrc == msrc_reg) ? q.other_reg : (q.msrc == msrc_mem) ? q.mem : q.dest;
    c = cin;
    v = q.byte_op ? {8'h00, q.dest[7:0]} : q.dest;
    we = (n == 0) ? 3'h0 : 3'h6;
    if (q.op == op_push_imm) begin
      v = k;
      we = 3'h1;
    end else if (q.op == op_signed_immediate_multiply) begin
      v = 16'($signed(m) * $signed(k));
      we = 3'h2;
    end else begin
      for (int i = 0; i < n; i++) begin
        t = v[w-1];
        b = v[0];
        case (q.op)
          op_arith_shift_left_imm, op_logic_shift_left_imm: begin
            v = v << 1;
            c = t;
          end
          op_arith_shift_right_imm, op_logic_shift_right_imm: begin
            v = (v >> 1) | (16'(t) << (w - 1));
            c = b;
          end
          op_rotate_left_imm: begin
            v = (v << 1) | 16'(t);
            c = t;
          end
          op_rotate_right_imm: begin
            v = (v >> 1) | (16'(b) << (w - 1));
            c = b;
          end
          op_rotate_left_thru_carry: begin
            v = (v << 1) | 16'(c);
            c = t;
          end
          default: begin
            v = (v >> 1) | (16'(c) << (w - 1));
            c = b;
          end
        endcase
        v = q.byte_op ? (v & 16'h00FF) : v;
      end
    end
  endfunction

  // Command goes to the decoder model, which issues it one edge later
  task automatic run(input req_type q, input logic legal);
    logic [15:0] er;
    logic ec;
    logic [2:0] ew;
    expect_of(q, exp_c, er, ec, ew);
    @(posedge i_mclk);
    cmd <= q;
    cmd_valid <= 1'b1;
    @(posedge i_mclk);
    cmd_valid <= 1'b0;
    @(posedge i_mclk);
    #1;
    check(16'(rsp_valid), 16'(legal), "response strobe");
    if (legal) begin
      check(rsp.result, er, "result");
      check(16'({rsp.carry_we, rsp.dest_we, rsp.stack_we}), 16'(ew), "write strobes");
      if (ew[2]) check(16'(rsp.carry_flag), 16'(ec), "carry");
      if (ew[2]) exp_c = ec;
      last_res = er;
    end else begin
      check(rsp.result, last_res, "refused op result");
      check(16'({rsp.carry_we, rsp.dest_we, rsp.stack_we}), 16'h0000, "refused strobes");
    end
    @(posedge i_mclk);
    #1;
    check(16'(rsp_valid), 16'h0000, "strobe length");
    check(16'(p_carry), 16'(exp_c), "model carry");
    if (legal && ew[1]) check(p_dest, er, "model destination");
  endtask

  initial begin
    exp_c = 1'b0;
    last_res = RESULT_RESET;
    void'($urandom(69));
    repeat (8) @(posedge i_mclk);
    #1;
    check(16'(rsp_valid), 16'(RESP_VALID_RESET), "reset strobe");
    check(rsp.result, RSP_RESET.result, "reset result");
    @(posedge i_mclk);
    i_arst_n <= 1'b1;
    $display("test reset done");
    // Push and multiply corners, every multiplier source
    r = '0;
    r.imm_byte = 1'b1;
    r.imm = 16'h1280;
    run(r, 1'b1);
    r.imm_byte = 1'b0;
    run(r, 1'b1);
    r.op = op_signed_immediate_multiply;
    r.dest = 16'h7FFF;
    r.other_reg = 16'h8000;
    r.mem = 16'hFFFF;
    for (int s = 0; s < 4; s++) begin
      r.msrc = msrc_type'(s);
      r.imm_byte = s[0];
      r.imm = 16'h8003;
      run(r, 1'b1);
    end
    $display("test push_multiply done");
    // Every shift and rotate at boundary counts, byte and word
    for (int o = 2; o < 10; o++) begin
      for (int j = 0; j < 20; j++) begin
        r = '0;
        r.op = op_type'(o);
        r.byte_op = j[0];
        r.count = cnts[j/2];
        r.dest = 16'hA5C3 ^ 16'(j * 16'h1111);
        run(r, 1'b1);
      end
    end
    $display("test shift_rotate done");
    // Undefined op codes are dropped
    r.op = op_type'(4'hA);
    run(r, 1'b0);
    r.op = op_type'(4'hF);
    run(r, 1'b0);
    $display("test refused done");
    for (int i = 0; i < 300; i++) begin
      r.op = op_type'($urandom_range(0, 9));
      r.byte_op = 1'($urandom);
      r.imm_byte = 1'($urandom);
      r.msrc = msrc_type'($urandom_range(0, 3));
      r.count = 8'($urandom);
      r.imm = 16'($urandom);
      r.dest = 16'($urandom);
      r.other_reg = 16'($urandom);
      r.mem = 16'($urandom);
      run(r, 1'b1);
    end
    $display("test random done");
    give_verdict();
  end
endmodule
